// ===== design/acws_params.svh
`ifndef ACWS_PARAMS_SVH
`define ACWS_PARAMS_SVH
// control word field positions
`define ACWS_WRITE_BIT   11
`define ACWS_SEQ_HI_BIT  10
`define ACWS_CH_HI_BIT   7
`define ACWS_CH_LO_BIT   6
`define ACWS_PM_HI_BIT   5
`define ACWS_PM_LO_BIT   4
`define ACWS_SEQ_LO_BIT  3
`define ACWS_RANGE_BIT   1
`define ACWS_CODING_BIT  0
// transfer framing, in falling serial clock edges
`define ACWS_CTRL_EDGES  5'h0C
`define ACWS_MUX_EDGE    5'h0E
`define ACWS_XFER_EDGES  5'h10
// power mode codes and reset word (normal power, channel 0)
`define ACWS_PM_NORMAL   2'h3
`define ACWS_PM_FULL     2'h2
`define ACWS_PM_AUTO     2'h1
`define ACWS_CTRL_RST    12'h030
`endif

// ===== design/acws_pkg.sv
package acws_pkg;
  typedef logic [1:0]  acws_ch_t;
  typedef logic [11:0] acws_word_t;
  typedef logic [4:0]  acws_cnt_t;
  typedef enum logic {ACWS_IDLE, ACWS_XFER} acws_state_e;
endpackage : acws_pkg

// ===== design/acws_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "acws_params.svh"
// Overview of operation
// - write bit 1 loads next 11 bits
// - channel bits pick next conversion input
// - channel bits decode binary to inputs 0-3
// - mux switches on 14th falling edge
// - channel bits precede result on output
// - power bits 11 keep device powered
// - power bits 10 shut down, hold register
// - power bits 01 shut down after update
// - range bit picks input span
// - coding bit picks twos complement/binary
// - sequencer hi 0: channel from last write
// - sequencer 10 keeps running sequence going
// - sequencer 11 steps channel 0 to final
// - 16 clocks, first 12 bits captured
// - output 00, channel, 12 bits, falling edges
// - sequence starts at channel 0 next
module acws_top (
  input  wire logic               clk_sys_i,
  input  wire logic               resetn_i,
  input  wire logic               sclk_i,
  input  wire logic               cs_n_i,
  input  wire logic               din_i,
  input  wire logic [11:0]        conv_data_i,
  output var  logic               dout_o,
  output var  acws_pkg::acws_ch_t mux_ch_o,
  output var  logic               range_ref_o,
  output var  logic               coding_binary_o,
  output var  logic               shutdown_o,
  output var  logic               seq_active_o,
  output var  acws_pkg::acws_word_t ctrl_word_o
);
  import acws_pkg::*;

  // ********************************************
  // pin synchronisers
  // ********************************************
  logic        sclk_s1_reg, sclk_s2_reg, sclk_d_reg;
  logic        cs_s1_reg, cs_s2_reg, cs_d_reg;
  logic        din_s1_reg, din_s2_reg;

  // two flops per pin; the third stage only feeds edge detection
  // reset loads the idle pin levels, so no false edge follows reset
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      {sclk_s1_reg, sclk_s2_reg, sclk_d_reg} <= 3'h7;
      {cs_s1_reg, cs_s2_reg, cs_d_reg}       <= 3'h7;
      {din_s1_reg, din_s2_reg}               <= 2'h0;
    end else begin
      {sclk_s1_reg, sclk_s2_reg, sclk_d_reg} <= {sclk_i, sclk_s1_reg, sclk_s2_reg};
      {cs_s1_reg, cs_s2_reg, cs_d_reg}       <= {cs_n_i, cs_s1_reg, cs_s2_reg};
      {din_s1_reg, din_s2_reg}               <= {din_i, din_s1_reg};
    end
  end

  // ********************************************
  // framing and edge count
  // ********************************************
  acws_state_e state_reg, state_next;
  acws_cnt_t   edge_cnt_reg, edge_cnt_next;
  acws_word_t  in_sh_reg, in_sh_next;
  // edges come from the second and third stages, so din, taken at the
  // same instant, has already passed its two flops
  wire logic   cs_fall   = cs_d_reg & ~cs_s2_reg;
  wire logic   cs_rise   = ~cs_d_reg & cs_s2_reg;
  wire logic   sclk_fall = sclk_d_reg & ~sclk_s2_reg;
  wire logic   in_xfer   = (state_reg == ACWS_XFER);
  wire logic   xfer_fall = in_xfer & sclk_fall & (edge_cnt_reg != `ACWS_XFER_EDGES);
  wire logic   cap_bit   = xfer_fall & (edge_cnt_reg < `ACWS_CTRL_EDGES);
  wire logic   cap_done  = cap_bit & (edge_cnt_reg == `ACWS_CTRL_EDGES - 5'h01);
  wire logic   mux_step  = xfer_fall & (edge_cnt_reg == `ACWS_MUX_EDGE - 5'h01);
  wire logic   conv_end  = xfer_fall & (edge_cnt_reg == `ACWS_XFER_EDGES - 5'h01);

  // frame state: chip select alone opens and closes a transfer
  // a frame cut short by chip select stops counting; the next fall
  // restarts the count from zero
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ACWS_IDLE: if (cs_fall) state_next = ACWS_XFER;
      ACWS_XFER: if (cs_rise) state_next = ACWS_IDLE;
    endcase
  end

  // only the first twelve falling edges carry control bits, msb first
  // edges past the sixteenth are dropped until the next frame
  assign edge_cnt_next = cs_fall ? 5'h00 : (xfer_fall ? edge_cnt_reg + 5'h01 : edge_cnt_reg);
  assign in_sh_next    = cap_bit ? {in_sh_reg[10:0], din_s2_reg} : in_sh_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_reg    <= ACWS_IDLE;
      edge_cnt_reg <= 5'h00;
      in_sh_reg    <= 12'h000;
    end else begin
      state_reg    <= state_next;
      edge_cnt_reg <= edge_cnt_next;
      in_sh_reg    <= in_sh_next;
    end
  end

  // ********************************************
  // control word load
  // ********************************************
  acws_word_t  ctrl_reg, ctrl_next;
  logic        wr_this_reg, wr_this_next;
  wire acws_word_t new_word = {in_sh_reg[10:0], din_s2_reg};
  wire logic   do_load   = cap_done & new_word[`ACWS_WRITE_BIT];

  // write bit 0 discards the word; don't-care bits are stored and seen only on ctrl_word_o
  assign ctrl_next    = do_load ? new_word : ctrl_reg;
  // a load landing together with a frame start wins over the clear
  assign wr_this_next = do_load ? 1'b1 : (cs_fall ? 1'b0 : wr_this_reg);

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ctrl_reg    <= `ACWS_CTRL_RST;
      wr_this_reg <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      wr_this_reg <= wr_this_next;
    end
  end

  // ********************************************
  // channel sequencer
  // ********************************************
  acws_ch_t    mux_ch_next;
  logic        seq_next;
  wire acws_ch_t ch_field = {ctrl_reg[`ACWS_CH_HI_BIT], ctrl_reg[`ACWS_CH_LO_BIT]};
  wire logic   seq_hi    = ctrl_reg[`ACWS_SEQ_HI_BIT];
  wire logic   seq_lo    = ctrl_reg[`ACWS_SEQ_LO_BIT];
  wire logic   seq_start = wr_this_reg & seq_hi & seq_lo;
  wire logic   seq_stop  = wr_this_reg & ~seq_hi;
  // the final channel is read live, so a 10 write may move the wrap point
  wire acws_ch_t seq_step = (mux_ch_o == ch_field) ? 2'h0 : mux_ch_o + 2'h1;

  // selection: stop wins, then (re)start, then running step, then plain write
  assign mux_ch_next = !mux_step  ? mux_ch_o     :
                       seq_stop   ? ch_field     :
                       seq_start  ? 2'h0         :
                       seq_active_o ? seq_step   :
                       wr_this_reg ? ch_field    : mux_ch_o;
  assign seq_next    = !mux_step ? seq_active_o :
                       seq_stop  ? 1'b0 : (seq_start ? 1'b1 : seq_active_o);

  // a running sequence survives 10 writes; only a write with 0x stops it
  // the mux only moves on the fourteenth edge, clear of the sampled input
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      mux_ch_o     <= 2'h0;
      seq_active_o <= 1'b0;
    end else begin
      mux_ch_o     <= mux_ch_next;
      seq_active_o <= seq_next;
    end
  end

  // ********************************************
  // power management
  // ********************************************
  logic        shut_next;
  wire logic [1:0] pm = {ctrl_reg[`ACWS_PM_HI_BIT], ctrl_reg[`ACWS_PM_LO_BIT]};

  // code 00 is refused by the host; here it simply falls through to auto hold
  // auto mode wakes on the next frame start; host owns the wake-up wait
  assign shut_next = (pm == `ACWS_PM_FULL)   ? 1'b1 :
                     (pm == `ACWS_PM_NORMAL) ? 1'b0 :
                     (conv_end & wr_this_reg) ? 1'b1 :
                     cs_fall ? 1'b0 : shutdown_o;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) shutdown_o <= 1'b0;
    else           shutdown_o <= shut_next;
  end

  // ********************************************
  // result shifter and outputs
  // ********************************************
  // sixteen-bit frame shifter; all zero outside a frame
  logic [15:0] out_sh_reg, out_sh_next;
  wire logic   coding_bin = ctrl_reg[`ACWS_CODING_BIT];
  // trade-off: data is taken at the frame start with no ready handshake,
  // so the core must have its result steady by then
  // core delivers straight binary; twos complement flips the msb
  wire logic [11:0] fmt_data = coding_bin ? conv_data_i :
                               {~conv_data_i[11], conv_data_i[10:0]};

  // frame: two zeros, channel of this conversion, then data msb first
  assign out_sh_next = cs_fall   ? {2'h0, mux_ch_o, fmt_data} :
                       xfer_fall ? {out_sh_reg[14:0], 1'b0}   :
                       cs_rise   ? 16'h0000 : out_sh_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      out_sh_reg      <= 16'h0000;
      dout_o          <= 1'b0;
      range_ref_o     <= 1'b0;
      coding_binary_o <= 1'b0;
      ctrl_word_o     <= `ACWS_CTRL_RST;
    end else begin
      out_sh_reg      <= out_sh_next;
      dout_o          <= out_sh_next[15];
      range_ref_o     <= ctrl_next[`ACWS_RANGE_BIT];
      coding_binary_o <= ctrl_next[`ACWS_CODING_BIT];
      ctrl_word_o     <= ctrl_next;
    end
  end

  // ********************************************
  // assertions
  // ********************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // control word load and edge count

  property p_load_on_write;
    cap_done & new_word[11] |=> ctrl_reg == $past(new_word);
  endproperty
  a_load_on_write: assert property (p_load_on_write) else $error("word not loaded");
  property p_hold_no_write;
    cap_done & ~new_word[11] |=> $stable(ctrl_reg);
  endproperty
  a_hold_no_write: assert property (p_hold_no_write) else $error("word loaded");
  property p_range_sel;
    do_load |=> range_ref_o == $past(new_word[`ACWS_RANGE_BIT]);
  endproperty
  a_range_sel: assert property (p_range_sel) else $error("span bit not applied");
  property p_coding_sel;
    do_load |=> coding_binary_o == $past(new_word[`ACWS_CODING_BIT]);
  endproperty
  a_coding_sel: assert property (p_coding_sel) else $error("coding bit not applied");
  property p_cnt_bound;
    edge_cnt_reg <= `ACWS_XFER_EDGES;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("edge count past frame end");

  // channel sequencer
  property p_mux_only_14;
    ~mux_step |=> $stable(mux_ch_o);
  endproperty
  a_mux_only_14: assert property (p_mux_only_14) else $error("mux moved off edge");
  property p_single_ch;
    mux_step & seq_stop |=> mux_ch_o == $past(ch_field) && !seq_active_o;
  endproperty
  a_single_ch: assert property (p_single_ch) else $error("bad single channel");
  property p_seq_start;
    mux_step & seq_start |=> mux_ch_o == 2'h0 && seq_active_o;
  endproperty
  a_seq_start: assert property (p_seq_start) else $error("sequence not at 0");
  property p_seq_step;
    mux_step & seq_active_o & ~wr_this_reg & (mux_ch_o != ch_field)
      |=> mux_ch_o == $past(mux_ch_o) + 2'h1;
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("sequence did not step");
  property p_seq_keep;
    mux_step & seq_active_o & wr_this_reg & seq_hi & ~seq_lo |=> seq_active_o;
  endproperty
  a_seq_keep: assert property (p_seq_keep) else $error("sequence broken by write");
  property p_seq_wrap;
    mux_step & seq_active_o & ~wr_this_reg & (mux_ch_o == ch_field) |=> mux_ch_o == 2'h0;
  endproperty
  a_seq_wrap: assert property (p_seq_wrap) else $error("no wrap");

  // power management
  property p_full_shut;
    pm == `ACWS_PM_FULL |=> shutdown_o;
  endproperty
  a_full_shut: assert property (p_full_shut) else $error("not shut down");
  property p_normal_on;
    pm == `ACWS_PM_NORMAL |=> !shutdown_o;
  endproperty
  a_normal_on: assert property (p_normal_on) else $error("shut in normal");
  property p_auto_shut;
    conv_end & wr_this_reg & (pm == `ACWS_PM_AUTO) |=> shutdown_o;
  endproperty
  a_auto_shut: assert property (p_auto_shut) else $error("no auto shutdown");

  // result frame
  property p_lead_zeros;
    cs_fall |=> !dout_o && out_sh_reg[13:12] == $past(mux_ch_o);
  endproperty
  a_lead_zeros: assert property (p_lead_zeros) else $error("bad result header");
  property p_out_shift;
    xfer_fall |=> dout_o == $past(out_sh_reg[14]);
  endproperty
  a_out_shift: assert property (p_out_shift) else $error("result bit out of order");

  // main scenarios worth seeing
  c_write:    cover property (do_load);
  c_seq_wrap: cover property (mux_step & seq_active_o & (mux_ch_o == ch_field));
  c_auto:     cover property (conv_end & wr_this_reg & (pm == `ACWS_PM_AUTO));
  c_seq_keep: cover property (mux_step & seq_active_o & wr_this_reg & seq_hi & ~seq_lo);
  c_full:     cover property ((pm == `ACWS_PM_FULL) & shutdown_o);
endmodule : acws_top
`default_nettype wire

// ===== test/acws_host.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// host serial master: frames, clocks and reads the converter
// ************************************************************
module acws_host (
  input  wire logic        clk_i,
  input  wire logic        dout_i,
  output var  logic        cs_n_o,
  output var  logic        sclk_o,
  output var  logic        din_o,
  output var  logic        rx_valid_o,
  output var  logic [15:0] rx_word_o
);
  // serial clock idles high and stands still between frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    din_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_word_o = 16'h0000;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk_i);
  endtask : hold
  // din set in the high phase so it is settled well before the fall
  task automatic xfer(input logic [15:0] w);
    logic [15:0] r;
    cs_n_o = 1'b0;
    for (int k = 15; k >= 0; k--) begin
      din_o = w[k];
      hold(8);
      r[k] = dout_i; // sampled just before the fall that advances it
      sclk_o = 1'b0;
      hold(8);
      sclk_o = 1'b1;
    end
    cs_n_o = 1'b1;
    din_o = ~din_o; // released line shows no stale level
    hold(110); // more than 1 us gap before the next valid frame
    rx_word_o = r;
    rx_valid_o = 1'b1;
    hold(1);
    rx_valid_o = 1'b0;
  endtask : xfer
endmodule : acws_host
`default_nettype wire

// ===== test/tb_acws_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "acws_params.svh"
// ************************************************************
// bench: reference model, expectation queue, output monitor
// ************************************************************
module tb_acws_top;
  import acws_pkg::*;
  typedef struct packed {logic [15:0] rx; logic [17:0] st;} acws_exp_s;
  logic        clk_sys_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [11:0] conv_data_i = 12'h000;
  logic        sclk, cs_n, din, dout, rx_valid, range_ref, coding_bin, shut, seq_act;
  logic [15:0] rx_word;
  acws_ch_t    mux_ch;
  acws_word_t  ctrl_word, m_ctrl, w;
  acws_ch_t    m_mux;
  logic        m_sd, m_seq;
  acws_exp_s   q[$];
  acws_exp_s   got;
  int          n_fail = 0;
  int          checked = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  acws_top dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .din_i(din), .conv_data_i(conv_data_i), .dout_o(dout), .mux_ch_o(mux_ch),
    .range_ref_o(range_ref), .coding_binary_o(coding_bin), .shutdown_o(shut),
    .seq_active_o(seq_act), .ctrl_word_o(ctrl_word));
  acws_host host_u (.clk_i(clk_sys_i), .dout_i(dout), .cs_n_o(cs_n), .sclk_o(sclk),
    .din_o(din), .rx_valid_o(rx_valid), .rx_word_o(rx_word));
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // model predicts the frame's result word and the state left behind
  task automatic send(input acws_word_t cw);
    acws_exp_s   e;
    logic [11:0] d;
    d = 12'($urandom);
    @(negedge clk_sys_i) conv_data_i = d;
    e.rx = {2'b00, m_mux, m_ctrl[0] ? d : {~d[11], d[10:0]}};
    if (cw[11]) m_ctrl = cw;
    if (cw[11] && !cw[10]) begin
      m_mux = cw[7:6];
      m_seq = 1'b0;
    end else if (cw[11] && cw[3]) begin
      m_mux = 2'h0;
      m_seq = 1'b1;
    end else if (m_seq) m_mux = (m_mux == m_ctrl[7:6]) ? 2'h0 : m_mux + 2'h1;
    else if (cw[11]) m_mux = cw[7:6];
    m_sd = (m_ctrl[5:4] == `ACWS_PM_FULL) || (m_ctrl[5:4] == `ACWS_PM_AUTO && cw[11]);
    e.st = {m_ctrl, m_mux, m_ctrl[1], m_ctrl[0], m_sd, m_seq};
    q.push_back(e);
    host_u.xfer({cw, 4'($urandom)});
  endtask : send
  // monitor: each finished frame is matched against the oldest note
  always @(posedge clk_sys_i) begin
    if (rx_valid === 1'b1) begin
      got = q.pop_front();
      chk(18'(rx_word), 18'(got.rx));
      chk({ctrl_word, mux_ch, range_ref, coding_bin, shut, seq_act}, got.st);
    end
  end
  // test sequence
  initial begin
    m_ctrl = `ACWS_CTRL_RST;
    m_mux = 2'h0;
    m_sd = 1'b0;
    m_seq = 1'b0;
    void'($urandom(32'hE5BE));
    repeat (6) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    @(negedge clk_sys_i);
    chk({ctrl_word, mux_ch, range_ref, coding_bin, shut, seq_act}, {`ACWS_CTRL_RST, 6'h00});
    send(12'h4C3);
    $display("test write_disabled done");
    for (int c = 0; c < 5; c++) send({4'h8, 2'(c), 2'h3, 4'h0});
    $display("test channels done");
    for (int r = 0; r < 4; r++) send({4'h8, 2'h1, 2'h3, 2'h0, 2'(r)});
    $display("test span_coding done");
    send(12'h820);
    send(12'h000);
    send(12'h810);
    send(12'h000);
    send(12'h830);
    $display("test power done");
    send(12'hCB8);
    repeat (4) send(12'h000);
    send(12'hCB1);
    send(12'h000);
    send(12'hC72);
    send(12'h8F0);
    send(12'h000);
    $display("test sequencer done");
    repeat (10) begin
      w = 12'($urandom);
      if (w[5:4] == 2'h0) w[4] = 1'b1;
      send(w);
    end
    $display("test random done");
    repeat (20) @(negedge clk_sys_i);
    chk(18'(q.size()), 18'h00000);
    complete_run();
  end
endmodule : tb_acws_top
`default_nettype wire
